// ===== verilog/jip_tap_port.v
// Purpose: Test access port with instruction decode, data registers, user chains and pin control
// Assumes: tck, tms, tdi and pin inputs are asynchronous; tck is far slower than clk
// Notes:   Programming codes are parameters; flash sequencing lives outside this block
//
// Overview of operation
// RULE1 - Identification code loads a 32-bit ID register between tdi and tdo.
// RULE2 - High-impedance code inserts one bypass bit and tri-states all user pins.
// RULE3 - Clamp code inserts bypass bit while pins follow the boundary register.
// RULE4 - Two user chain codes each select their own chain in user logic.
// RULE5 - During user chains, tdi and TAP state go to user logic.
// RULE6 - High-impedance, clamp and external test keep pull-ups and bus-hold as configured.
// RULE7 - Host loads only supported codes; unknown codes fall back to bypass here.
// RULE8 - Instruction register is 10 bits, user code register 32 bits.
// RULE9 - Boundary register length is a size parameter: 240, 480, 636 or 816.
// RULE10 - ID is version, part number, maker code, then a one in bit zero.
// RULE11 - During programming, pins float with weak pull-ups enabled.
// RULE12 - Until programming-complete flag is set, no pin drives.
// RULE13 - Host starts programming only after power-up and configuration are done.
// RULE14 - Programming data enters on tdi; read data returns on tdo.
// RULE15 - Programming instruction codes are parameters, not fixed values.
// RULE16 - Sample code captures pin states and allows preloading the boundary register.
// RULE17 - External test drives pins from boundary register and captures inputs.
// RULE18 - Unprogrammed user code reads as all ones.
// RULE19 - Instruction capture loads a pattern ending in binary 01.
`timescale 1ns/1ps
`default_nettype none
`include "jip_consts.vh"

module jip_tap_port #(
  parameter        NUM_IO     = 80,
  parameter        BSR_LEN    = `JIP_BSR_LEN_DEF,
  parameter        ISC_LEN    = 16,
  parameter [3:0]  ID_VERSION = 4'h0,      // Arbitrary value
  parameter [15:0] ID_PART    = 16'h1234,  // Arbitrary value
  parameter [10:0] ID_MAKER   = 11'h155,   // Arbitrary value
  parameter [9:0]  OP_ISC_ENTER = 10'h2cc, // Programming entry code
  parameter [9:0]  OP_ISC_EXIT  = 10'h201, // Programming exit code
  parameter [9:0]  OP_ISC_DATA  = 10'h2f2  // Programming data access code
) (
  // Clock and reset
  input  wire               clk,
  input  wire               reset,
  input  wire               clk_en,
  // Test port pins
  input  wire               tck,
  input  wire               tms,
  input  wire               tdi,
  output reg                tdo,
  output reg                tdo_oe,
  // User pins, core side
  input  wire [NUM_IO-1:0]  core_out,
  input  wire [NUM_IO-1:0]  core_oe,
  input  wire [NUM_IO-1:0]  cfg_pullup,
  input  wire [NUM_IO-1:0]  cfg_bushold,
  // User pins, pad side
  input  wire [NUM_IO-1:0]  pin_in,
  output reg  [NUM_IO-1:0]  pin_out,
  output reg  [NUM_IO-1:0]  pin_oe,
  output reg  [NUM_IO-1:0]  pin_pullup,
  output reg  [NUM_IO-1:0]  pin_bushold,
  // Flash status
  input  wire               programming_complete_flag,
  input  wire               usercode_valid,
  input  wire [31:0]        usercode_value,
  // Programming data path
  input  wire [ISC_LEN-1:0] isc_rdata,
  output reg  [ISC_LEN-1:0] isc_wdata,
  output reg                isc_write,
  output reg                in_system_programming,
  // User chains
  output reg                user_chain_a,
  output reg                user_chain_b,
  output reg                user_tdi,
  output reg  [3:0]         user_state,
  output wire               user_tck_rise,
  input  wire               user_tdo_a,
  input  wire               user_tdo_b
);

  //////////////////////////////////////////////////////////////////////////////
  // TAP states, standard encoding
  localparam [3:0] S_EX2DR = 4'h0, S_EX1DR = 4'h1, S_SHDR = 4'h2, S_PSDR = 4'h3;
  localparam [3:0] S_SELIR = 4'h4, S_UPDR = 4'h5, S_CAPDR = 4'h6, S_SELDR = 4'h7;
  localparam [3:0] S_EX2IR = 4'h8, S_EX1IR = 4'h9, S_SHIR = 4'ha, S_PSIR = 4'hb;
  localparam [3:0] S_RTI = 4'hc, S_UPIR = 4'hd, S_CAPIR = 4'he, S_TLR = 4'hf;

  function [3:0] tap_next;
    input [3:0] s;
    input       m;
    begin
      case (s)
        S_TLR:   tap_next = m ? S_TLR : S_RTI;
        S_RTI:   tap_next = m ? S_SELDR : S_RTI;
        S_SELDR: tap_next = m ? S_SELIR : S_CAPDR;
        S_CAPDR: tap_next = m ? S_EX1DR : S_SHDR;
        S_SHDR:  tap_next = m ? S_EX1DR : S_SHDR;
        S_EX1DR: tap_next = m ? S_UPDR : S_PSDR;
        S_PSDR:  tap_next = m ? S_EX2DR : S_PSDR;
        S_EX2DR: tap_next = m ? S_UPDR : S_SHDR;
        S_UPDR:  tap_next = m ? S_SELDR : S_RTI;
        S_SELIR: tap_next = m ? S_TLR : S_CAPIR;
        S_CAPIR: tap_next = m ? S_EX1IR : S_SHIR;
        S_SHIR:  tap_next = m ? S_EX1IR : S_SHIR;
        S_EX1IR: tap_next = m ? S_UPIR : S_PSIR;
        S_PSIR:  tap_next = m ? S_EX2IR : S_PSIR;
        S_EX2IR: tap_next = m ? S_UPIR : S_SHIR;
        S_UPIR:  tap_next = m ? S_SELDR : S_RTI;
        default: tap_next = S_TLR;
      endcase
    end
  endfunction

  // Unknown codes select bypass so the chain length stays predictable
  function [2:0] dr_select;
    input [9:0] op;
    begin
      if (op == `JIP_OP_IDCODE)
        dr_select = `JIP_SEL_ID;                                   // RULE1
      else if (op == `JIP_OP_USERCODE)
        dr_select = `JIP_SEL_UC;
      else if (op == `JIP_OP_SAMPLE || op == `JIP_OP_EXTEST)
        dr_select = `JIP_SEL_BSR;                                  // RULE16
      else if (op == `JIP_OP_CHAIN_A)
        dr_select = `JIP_SEL_UA;                                   // RULE4
      else if (op == `JIP_OP_CHAIN_B)
        dr_select = `JIP_SEL_UB;                                   // RULE4
      else if (op == OP_ISC_DATA)
        dr_select = `JIP_SEL_ISC;                                  // RULE15
      else
        dr_select = `JIP_SEL_BYP;                                  // RULE2 RULE3 RULE7
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers; first stages feed only the second stages
  reg              tck_s1, tck_s2, tck_s3;
  reg              tms_s1, tms_s2, tdi_s1, tdi_s2;
  reg [NUM_IO-1:0] pin_s1, pin_s2;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      {tck_s1, tck_s2, tck_s3} <= 3'h0;
      {tms_s1, tms_s2, tdi_s1, tdi_s2} <= 4'hf;
      pin_s1 <= {NUM_IO{1'b0}};
      pin_s2 <= {NUM_IO{1'b0}};
    end else if (clk_en) begin
      {tck_s1, tck_s2, tck_s3} <= {tck, tck_s1, tck_s2};
      {tms_s1, tms_s2, tdi_s1, tdi_s2} <= {tms, tms_s1, tdi, tdi_s1};
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
    end
  end

  wire tck_rise = clk_en & tck_s2 & ~tck_s3;
  wire tck_fall = clk_en & ~tck_s2 & tck_s3;
  assign user_tck_rise = tck_rise & (user_chain_a | user_chain_b);  // RULE5

  //////////////////////////////////////////////////////////////////////////////
  // Registers of the port
  reg [3:0]         state_reg;
  reg [9:0]         ir_sh_reg, ir_reg;
  reg               byp_reg;
  reg [31:0]        id_sh_reg;
  reg [BSR_LEN-1:0] bsr_sh_reg, bsr_upd_reg;
  reg [ISC_LEN-1:0] isc_sh_reg;
  wire [2:0]        sel = dr_select(ir_reg);
  wire [31:0]       id_word = {ID_VERSION, ID_PART, ID_MAKER, `JIP_ID_LSB};  // RULE10
  wire [31:0]       uc_word = usercode_valid ? usercode_value : `JIP_USERCODE_BLANK;  // RULE18

  // Boundary capture: inputs from pads, outputs and enables from what pins show
  wire [BSR_LEN-1:0] bsr_cap;
  genvar g;
  generate
    for (g = 0; g < BSR_LEN; g = g + 1) begin : g_cap
      if (g / `JIP_CELLS_PER_IO < NUM_IO) begin : g_pin
        if (g % `JIP_CELLS_PER_IO == `JIP_CELL_IN)
          assign bsr_cap[g] = pin_s2[g / `JIP_CELLS_PER_IO];          // RULE16 RULE17
        else if (g % `JIP_CELLS_PER_IO == `JIP_CELL_OUT)
          assign bsr_cap[g] = pin_out[g / `JIP_CELLS_PER_IO];
        else
          assign bsr_cap[g] = pin_oe[g / `JIP_CELLS_PER_IO];
      end else begin : g_spare
        assign bsr_cap[g] = 1'b0;
      end
    end
  endgenerate

  // Rising tck: advance, capture, shift
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg  <= S_TLR;
      ir_sh_reg  <= `JIP_IR_CAPTURE;
      byp_reg    <= 1'b0;
      id_sh_reg  <= 32'h0;
      bsr_sh_reg <= {BSR_LEN{1'b0}};
      isc_sh_reg <= {ISC_LEN{1'b0}};
      user_tdi   <= 1'b0;
    end else if (tck_rise) begin
      state_reg <= tap_next(state_reg, tms_s2);
      user_tdi  <= tdi_s2;                                          // RULE5
      if (state_reg == S_CAPIR)
        ir_sh_reg <= `JIP_IR_CAPTURE;                               // RULE19
      else if (state_reg == S_SHIR)
        ir_sh_reg <= {tdi_s2, ir_sh_reg[9:1]};                      // RULE8
      if (state_reg == S_CAPDR) begin
        byp_reg <= 1'b0;
        if (sel == `JIP_SEL_ID)
          id_sh_reg <= id_word;                                     // RULE1
        else if (sel == `JIP_SEL_UC)
          id_sh_reg <= uc_word;                                     // RULE8
        if (sel == `JIP_SEL_BSR)
          bsr_sh_reg <= bsr_cap;                                    // RULE16 RULE17
        if (sel == `JIP_SEL_ISC)
          isc_sh_reg <= isc_rdata;                                  // RULE14
      end else if (state_reg == S_SHDR) begin
        byp_reg <= tdi_s2;
        if (sel == `JIP_SEL_ID || sel == `JIP_SEL_UC)
          id_sh_reg <= {tdi_s2, id_sh_reg[31:1]};
        if (sel == `JIP_SEL_BSR)
          bsr_sh_reg <= {tdi_s2, bsr_sh_reg[BSR_LEN-1:1]};          // RULE9
        if (sel == `JIP_SEL_ISC)
          isc_sh_reg <= {tdi_s2, isc_sh_reg[ISC_LEN-1:1]};          // RULE14
      end
    end
  end

  // Falling tck: update registers and drive tdo; test-logic-reset restores identification
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ir_reg      <= `JIP_OP_IDCODE;
      bsr_upd_reg <= {BSR_LEN{1'b0}};
      isc_wdata   <= {ISC_LEN{1'b0}};
      isc_write   <= 1'b0;
      in_system_programming <= 1'b0;
      tdo         <= 1'b0;
      tdo_oe      <= 1'b0;
    end else if (clk_en) begin
      isc_write <= 1'b0;
      if (tck_fall) begin
        tdo_oe <= (state_reg == S_SHIR) || (state_reg == S_SHDR);
        if (state_reg == S_SHIR)
          tdo <= ir_sh_reg[0];
        else begin
          case (sel)
            `JIP_SEL_ID, `JIP_SEL_UC: tdo <= id_sh_reg[0];          // RULE1 RULE8
            `JIP_SEL_BSR: tdo <= bsr_sh_reg[0];
            `JIP_SEL_UA:  tdo <= user_tdo_a;                        // RULE4
            `JIP_SEL_UB:  tdo <= user_tdo_b;                        // RULE4
            `JIP_SEL_ISC: tdo <= isc_sh_reg[0];                     // RULE14
            default:      tdo <= byp_reg;                           // RULE2 RULE3
          endcase
        end
        if (state_reg == S_TLR) begin
          ir_reg <= `JIP_OP_IDCODE;
          in_system_programming <= 1'b0;
        end else if (state_reg == S_UPIR) begin
          ir_reg <= ir_sh_reg;
          if (ir_sh_reg == OP_ISC_ENTER)
            in_system_programming <= 1'b1;                          // RULE15
          else if (ir_sh_reg == OP_ISC_EXIT)
            in_system_programming <= 1'b0;
        end
        if (state_reg == S_UPDR && sel == `JIP_SEL_BSR)
          bsr_upd_reg <= bsr_sh_reg;                                // RULE16
        if (state_reg == S_UPDR && sel == `JIP_SEL_ISC) begin
          isc_wdata <= isc_sh_reg;                                  // RULE14
          isc_write <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // User chain strobes and exposed TAP state
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      user_chain_a <= 1'b0;
      user_chain_b <= 1'b0;
      user_state   <= S_TLR;
    end else if (clk_en) begin
      user_chain_a <= (sel == `JIP_SEL_UA);                         // RULE5
      user_chain_b <= (sel == `JIP_SEL_UB);                         // RULE5
      user_state   <= state_reg;                                    // RULE5
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pad drive; priority is flag, programming, high-impedance, boundary, core
  wire mode_highz = (ir_reg == `JIP_OP_HIGHZ);
  wire mode_bsr   = (ir_reg == `JIP_OP_CLAMP) || (ir_reg == `JIP_OP_EXTEST);
  integer i;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_out     <= {NUM_IO{1'b0}};
      pin_oe      <= {NUM_IO{1'b0}};
      pin_pullup  <= {NUM_IO{1'b1}};
      pin_bushold <= {NUM_IO{1'b0}};
    end else if (clk_en) begin
      for (i = 0; i < NUM_IO; i = i + 1) begin
        pin_bushold[i] <= cfg_bushold[i] & ~in_system_programming;  // RULE6
        pin_pullup[i]  <= cfg_pullup[i] | in_system_programming;    // RULE6 RULE11
        if (!programming_complete_flag || in_system_programming || mode_highz) begin
          pin_out[i] <= 1'b0;                                       // RULE12 RULE11 RULE2
          pin_oe[i]  <= 1'b0;
        end else if (mode_bsr) begin
          pin_out[i] <= bsr_upd_reg[i*`JIP_CELLS_PER_IO+`JIP_CELL_OUT];  // RULE3 RULE17
          pin_oe[i]  <= bsr_upd_reg[i*`JIP_CELLS_PER_IO+`JIP_CELL_OE];
        end else begin
          pin_out[i] <= core_out[i];
          pin_oe[i]  <= core_oe[i];
        end
      end
    end
  end

endmodule // jip_tap_port
`default_nettype wire

// ===== common/jip_consts.vh
// Purpose: Shared constants for the test access port and programming block
// Assumes: Included by its bare name from the design file
// Notes:   Instruction codes are ten bits wide, least significant bit shifted first
`ifndef JIP_CONSTS_VH
`define JIP_CONSTS_VH

// Register lengths
`define JIP_IR_LEN        10
`define JIP_ID_LEN        32
`define JIP_BSR_LEN_DEF   240

// Supported instruction codes
`define JIP_OP_SAMPLE     10'h005
`define JIP_OP_IDCODE     10'h006
`define JIP_OP_USERCODE   10'h007
`define JIP_OP_CLAMP      10'h00a
`define JIP_OP_HIGHZ      10'h00b
`define JIP_OP_CHAIN_A    10'h00c
`define JIP_OP_CHAIN_B    10'h00e
`define JIP_OP_EXTEST     10'h00f
`define JIP_OP_BYPASS     10'h3ff

// Instruction capture pattern, two low bits are 01
`define JIP_IR_CAPTURE    10'h001

// Identification layout
`define JIP_ID_LSB        1'h1
`define JIP_USERCODE_BLANK 32'hffffffff

// Boundary cell layout per pin
`define JIP_CELLS_PER_IO  3
`define JIP_CELL_IN       0
`define JIP_CELL_OUT      1
`define JIP_CELL_OE       2

// Data register selections
`define JIP_SEL_BYP       3'h0
`define JIP_SEL_ID        3'h1
`define JIP_SEL_UC        3'h2
`define JIP_SEL_BSR       3'h3
`define JIP_SEL_UA        3'h4
`define JIP_SEL_UB        3'h5
`define JIP_SEL_ISC       3'h6

`endif

// ===== bench/jip_tap_port_sva.sv
// Purpose: Assertions on pad control and test port outputs
// Assumes: Bound into jip_tap_port, one clock domain
// Notes:   Pad registers lag their cause by one clock
`timescale 1ns/1ps
`default_nettype none
module jip_tap_port_sva #(parameter NUM_IO = 80) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              reset,
  // Pad side
  input wire logic              programming_complete_flag,
  input wire logic              in_system_programming,
  input wire logic [NUM_IO-1:0] cfg_pullup,
  input wire logic [NUM_IO-1:0] cfg_bushold,
  input wire logic [NUM_IO-1:0] pin_oe,
  input wire logic [NUM_IO-1:0] pin_pullup,
  input wire logic [NUM_IO-1:0] pin_bushold,
  // Test port side
  input wire logic              user_chain_a,
  input wire logic              user_chain_b,
  input wire logic              user_tck_rise,
  input wire logic [3:0]        user_state,
  input wire logic              tdo_oe,
  input wire logic              isc_write
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////
  // Two samples in programming mode, so the pads have caught up
  sequence prog_held_s;
    in_system_programming ##1 in_system_programming;
  endsequence
  // Device programmed and not being reprogrammed
  sequence user_mode_s;
    programming_complete_flag && !in_system_programming;
  endsequence
  pad_off_flag_a: assert property (!programming_complete_flag |=> pin_oe == '0)
    else $error("pad drives while unprogrammed");
  prog_pads_float_a: assert property (prog_held_s |-> pin_oe == '0 && &pin_pullup && pin_bushold == '0)
    else $error("pads not floating in programming mode");
  pads_keep_cfg_a: assert property (user_mode_s |=> pin_pullup == $past(cfg_pullup) && pin_bushold == $past(cfg_bushold))
    else $error("pad options lost");
  one_chain_a: assert property (!(user_chain_a && user_chain_b))
    else $error("both user chains selected");
  chain_on_upd_a: assert property ($rose(user_chain_a) || $rose(user_chain_b) |-> user_state == 4'hd)
    else $error("user chain selected outside instruction update");
  rise_needs_chain_a: assert property (user_tck_rise |-> user_chain_a || user_chain_b)
    else $error("user clock strobe without chain");
  rise_one_clk_a: assert property (user_tck_rise |=> !user_tck_rise)
    else $error("user clock strobe too long");
  isc_write_upd_a: assert property (isc_write |-> user_state == 4'h5 ##1 !isc_write)
    else $error("program write outside update");
  tdo_oe_shift_a: assert property ($rose(tdo_oe) |-> user_state == 4'h2 || user_state == 4'ha)
    else $error("serial out enabled outside shift");
  prog_enter_upd_a: assert property ($rose(in_system_programming) |-> user_state == 4'hd)
    else $error("programming mode entered outside update");
endmodule // jip_tap_port_sva
bind jip_tap_port jip_tap_port_sva #(.NUM_IO(NUM_IO)) sva_u (.clk, .reset, .programming_complete_flag,
  .in_system_programming, .cfg_pullup, .cfg_bushold, .pin_oe, .pin_pullup, .pin_bushold, .user_chain_a,
  .user_chain_b, .user_tck_rise, .user_state, .tdo_oe, .isc_write);
`default_nettype wire

// ===== bench/jip_host.sv
// Purpose: Boundary-scan host driving the test pins
// Assumes: Test clock period is ten system clocks, 80 ns
// Notes:   Test clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module jip_host (
  // Clock
  input  wire logic clk,
  // Test port
  output var logic  tck,
  output var logic  tms,
  output var logic  tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One test clock; serial out is taken just before the rise
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge clk);
    #1;
    tms = m;
    tdi = d;
    repeat (4) @(posedge clk);
    #1;
    q = tdo;
    tck = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    tck = 1'b0;
  endtask
  // Walk mode select bits, first bit first
  task automatic walk(input logic [7:0] ms, input int n);
    logic q;
    for (int i = 0; i < n; i++) step(ms[i], tdi, q);
  endtask
  // Five ones reach reset from any state, then idle
  task automatic tap_reset;
    walk(8'b011111, 6);
  endtask
  // Full scan from idle back to idle, exact register length
  task automatic scan(input logic ir, input int n, input logic [239:0] din, output logic [239:0] dout);
    dout = '0;
    walk(ir ? 8'b0011 : 8'b0001, ir ? 4 : 3);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    walk(8'b01, 2);
    tdi = ~tdi; // Released line must not look stable
  endtask
endmodule // jip_host
`default_nettype wire

// ===== bench/jip_tap_port_test.sv
// Purpose: Self-checking bench for the test access port block
// Assumes: Host model paces the test pins from the system clock
// Notes:   Pads are checked a few clocks after each cause settles
`timescale 1ns/1ps
`default_nettype none
module jip_tap_port_test;
  localparam logic [3:0]  VER   = 4'h2;     // Arbitrary value
  localparam logic [15:0] PART  = 16'h4c1e; // Arbitrary value
  localparam logic [10:0] MAKER = 11'h0a3;  // Arbitrary value
  localparam logic [9:0]  ENTER = 10'h2cc;
  localparam logic [9:0]  LEAVE = 10'h201;
  localparam logic [9:0]  DATA  = 10'h2f2;
  logic         clk, reset, clk_en, tck, tms, tdi, tdo, tdo_oe, isc_write, in_system_programming;
  logic         programming_complete_flag, usercode_valid, user_tdo_a, user_tdo_b, user_tdi;
  logic         user_chain_a, user_chain_b, user_tck_rise;
  logic [3:0]   user_state;
  logic [15:0]  isc_rdata, isc_wdata;
  logic [31:0]  usercode_value;
  logic [79:0]  core_out, core_oe, cfg_pullup, cfg_bushold, pin_in, pin_out, pin_oe, pin_pullup, pin_bushold;
  logic [239:0] dq;
  int           n_errors = 0;
  int           n_compared = 0;
  jip_tap_port #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER), .OP_ISC_ENTER(ENTER),
    .OP_ISC_EXIT(LEAVE), .OP_ISC_DATA(DATA)) dut_u (.clk, .reset, .clk_en, .tck, .tms, .tdi, .tdo,
    .tdo_oe, .core_out, .core_oe, .cfg_pullup, .cfg_bushold, .pin_in, .pin_out, .pin_oe, .pin_pullup,
    .pin_bushold, .programming_complete_flag, .usercode_valid, .usercode_value, .isc_rdata, .isc_wdata,
    .isc_write, .in_system_programming, .user_chain_a, .user_chain_b, .user_tdi, .user_state,
    .user_tck_rise, .user_tdo_a, .user_tdo_b);
  jip_host host_u (.clk, .tck, .tms, .tdi, .tdo);
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string nm, input logic [79:0] seen, input logic [79:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ir(input logic [9:0] op);
    host_u.scan(1'b1, 10, 240'(op), dq);
  endtask
  task automatic dr(input int n, input logic [239:0] din);
    host_u.scan(1'b0, n, din, dq);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Input cells sit at every third position
  function automatic logic [79:0] ins(input logic [239:0] v);
    for (int i = 0; i < 80; i++) ins[i] = v[3*i];
  endfunction
  task automatic t_idcode;
    dr(32, '0);
    check("id_reset", 80'(dq[31:0]), 80'({VER, PART, MAKER, 1'b1}));
    ir(10'h006);
    check("ir_capture", 80'(dq[1:0]), 80'h1);
    dr(32, '0);
    check("idcode", 80'(dq[31:0]), 80'({VER, PART, MAKER, 1'b1}));
  endtask
  task automatic t_usercode;
    ir(10'h007);
    dr(32, '0);
    check("uc_blank", 80'(dq[31:0]), 80'(32'hffffffff));
    usercode_valid = 1'b1;
    dr(32, '0);
    check("uc_value", 80'(dq[31:0]), 80'(usercode_value));
  endtask
  task automatic t_highz;
    ir(10'h00b);
    dr(2, 240'h3);
    check("hz_bypass", 80'(dq[1:0]), 80'h2);
    settle;
    check("hz_oe", pin_oe, '0);
    check("hz_pull", pin_pullup, cfg_pullup);
    check("hz_hold", pin_bushold, cfg_bushold);
  endtask
  // Even pins drive low, odd pins hold a high but do not drive
  task automatic t_boundary;
    pin_in = 80'h9e3779b97f4a7c15f39c;
    ir(10'h005);
    dr(240, {40{6'b011101}});
    check("sample_in", ins(dq), pin_in);
    ir(10'h00f);
    settle;
    check("ext_out", pin_out, {40{2'b10}});
    check("ext_oe", pin_oe, {40{2'b01}});
    pin_in = ~pin_in;
    dr(240, {40{6'b011101}});
    check("ext_in", ins(dq), pin_in);
    ir(10'h00a);
    settle;
    check("clamp_out", pin_out, {40{2'b10}});
    check("clamp_oe", pin_oe, {40{2'b01}});
    check("clamp_pull", pin_pullup, cfg_pullup);
    check("clamp_hold", pin_bushold, cfg_bushold);
    dr(2, 240'h1);
    check("clamp_bypass", 80'(dq[1:0]), 80'h2);
  endtask
  task automatic t_chains;
    for (int k = 0; k < 2; k++) begin
      user_tdo_a = ~k[0];
      user_tdo_b = k[0];
      ir(k[0] ? 10'h00e : 10'h00c);
      check("chain_sel", 80'({user_chain_b, user_chain_a}), 80'(k[0] ? 2'b10 : 2'b01));
      dr(4, k[0] ? 240'h8 : 240'h0);
      check("chain_tdo", 80'(dq[3:0]), 80'hf);
      check("chain_tdi", 80'(user_tdi), 80'(k[0]));
      check("chain_state", 80'(user_state), 80'hc);
    end
  endtask
  // Programming starts only after reset, the reset walk and the earlier tests
  task automatic t_prog;
    ir(ENTER);
    settle;
    check("prog_on", 80'(in_system_programming), 80'h1);
    check("prog_oe", pin_oe, '0);
    check("prog_pull", pin_pullup, '1);
    isc_rdata = 16'hc35a;
    ir(DATA);
    dr(16, 240'h3c91);
    check("isc_rd", 80'(dq[15:0]), 80'h0c35a);
    check("isc_wr", 80'(isc_wdata), 80'h3c91);
    ir(LEAVE);
    check("prog_off", 80'(in_system_programming), 80'h0);
    programming_complete_flag = 1'b0;
    settle;
    check("flag_oe", pin_oe, '0);
    programming_complete_flag = 1'b1;
    settle;
    check("run_oe", pin_oe, core_oe);
    check("run_out", pin_out, core_out);
    // Clock enable low must freeze the pads against a core change
    clk_en = 1'b0;
    core_oe = '0;
    settle;
    check("frozen_oe", pin_oe, '1);
    clk_en = 1'b1;
    settle;
    check("thawed_oe", pin_oe, '0);
  endtask
  task automatic final_report;
    $display("Errors %0d, comparisons %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Whole run needs about 8800 clocks
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    final_report;
  end
  initial begin
    clk_en = 1'b1;
    reset = 1'b1;
    programming_complete_flag = 1'b1;
    usercode_valid = 1'b0;
    usercode_value = 32'h5ac30f96;
    isc_rdata = '0;
    user_tdo_a = 1'b0;
    user_tdo_b = 1'b0;
    core_out = {40{2'b01}};
    core_oe = '1;
    cfg_pullup = {20{4'h5}};
    cfg_bushold = {20{4'h3}};
    pin_in = '0;
    repeat (2) @(posedge clk);
    #1;
    reset = 1'b0;
    host_u.tap_reset;
    t_idcode;
    t_usercode;
    t_highz;
    t_boundary;
    t_chains;
    t_prog;
    final_report;
  end
endmodule // jip_tap_port_test
`default_nettype wire
